// *** arsr_defs.vh ***
// Constants for the auto run sequencer and start/stop supervisor.
// Assumes inclusion by bare name; definitions only.
`ifndef ARSR_DEFS_VH
`define ARSR_DEFS_VH
`define ARSR_MODE_OFF        3'h0
`define ARSR_MODE_MAX        3'h6
`define ARSR_DIR_STOP        2'h0
`define ARSR_DIR_FWD         2'h1
`define ARSR_DIR_REV         2'h2
`define ARSR_DI_FUNC_SEQ     5'h12
`define ARSR_FREQ_MAX        16'hE9FC
`define ARSR_TIME_MAX        16'h8CA0
`define ARSR_DCB_START_MIN   10'h00A
`define ARSR_DCB_START_MAX   10'h3E8
`define ARSR_RESTART_MAX     4'hA
`define ARSR_RESTART_DLY_MAX 14'h1F40
`define ARSR_INT_DELAY_MS    500
`define ARSR_CLK_HZ          50000000
`define ARSR_MS_CYCLES       (`ARSR_CLK_HZ / 1000)
`define ARSR_TICK_MS         100
`define ARSR_TICK_CYCLES     (`ARSR_MS_CYCLES * `ARSR_TICK_MS)
`define ARSR_INT_DELAY_TICKS (`ARSR_INT_DELAY_MS / `ARSR_TICK_MS)
`endif

// *** arsr_op_model.sv ***
// Operator side: run switch and multifunction input pins.
// Assumes the bench asks for switch levels; pins change after an edge.
module arsr_op_model (
  input  wire       clk_in,
  input  wire       run_req_in,
  input  wire       seq_req_in,
  output reg        run_sw_out = 1'b0,
  output reg  [4:0] di_pin_out = 5'h00
);
  // Pins 1-4 carry no function, so they toggle to expose decoding slips
  always @(posedge clk_in) begin
    run_sw_out <= run_req_in;
    di_pin_out <= {~di_pin_out[4:1], seq_req_in};
  end
endmodule // arsr_op_model

// *** arsr_seq.v ***
// Auto run sequencer with restart, reset-permission and power-up supervision.
// Assumes set-up values are static while running; pins pass a 2-FF synchroniser.
// Summary of operation
// [RULE1] Mode 0 disables sequencer; 1..6 pick cycle type and restart policy.
// [RULE2] Modes 1-3 resume the unfinished step; modes 4-6 restart at step 0.
// [RULE3] Modes 1 and 4 run each configured step once, then stop.
// [RULE4] Modes 2 and 5 wrap to step 0 while run persists.
// [RULE5] Modes 3 and 6 hold the final step frequency after one cycle.
// [RULE6] Steps 1 to 7 take their own frequency, 0 to 599.00 Hz.
// [RULE7] Step 0 frequency comes from the keypad preset.
// [RULE8] Each step has run time up to 3600.0 s, then advances.
// [RULE9] Each step has direction: 0 stop, 1 forward, 2 reverse.
// [RULE10] Sequencer only runs when an input with function 18 is asserted.
// [RULE11] Step changes use the normal accel/decel pair, no per-step ramp.
// [RULE12] Under-voltage stops the output immediately.
// [RULE13] Power-loss restart: 0 none, 1 restart at prior frequency, unlimited.
// [RULE14] Restart attempt count 0..10; zero disables fault auto restart.
// [RULE15] Auto restart after set delay up to 800.0 s; zero means 0.5 s.
// [RULE16] No fault auto restart during DC braking or deceleration to stop.
// [RULE17] Reset mode 0 accepts reset only with run off; 1 accepts always. Code ignores a reset while a fault auto restart is pending.
// [RULE18] Power-up direct run 0 with external control starts if switch on.
// [RULE19] Power-up direct run 1 blocks held switch and flashes an indication.
// [RULE20] DC braking on stop only if current and time settings nonzero.
// [RULE21] DC brake start below minimum frequency starts at minimum frequency.
// [RULE22] First zero-time step after step 0 ends the cycle.
`include "arsr_defs.vh"
module arsr_seq #(
  parameter TICK_CYCLES = `ARSR_TICK_CYCLES
) (
  // Clock and reset
  input  wire         clk_in,
  input  wire         rst_in,
  // Set-up values (static)
  input  wire [2:0]   seq_mode_in,
  input  wire [15:0]  keypad_freq_in,
  input  wire [111:0] step_freq_in,
  input  wire [127:0] step_time_in,
  input  wire [15:0]  step_dir_in,
  input  wire [24:0]  di_func_in,
  input  wire         pwr_loss_restart_in,
  input  wire [13:0]  restart_delay_in,
  input  wire [3:0]   restart_count_in,
  input  wire         reset_mode_in,
  input  wire         direct_run_off_in,
  input  wire         ext_run_sel_in,
  input  wire [7:0]   dcb_current_in,
  input  wire [7:0]   dcb_time_in,
  input  wire [9:0]   dcb_start_freq_in,
  input  wire [15:0]  min_freq_in,
  // Pins and drive status
  input  wire [4:0]   di_pin_in,
  input  wire         run_sw_in,
  input  wire         undervolt_in,
  input  wire         fault_in,
  input  wire         fault_reset_in,
  input  wire         decel_stop_in,
  input  wire [15:0]  out_freq_in,
  // Drive commands
  output reg  [15:0]  freq_cmd_out,
  output reg  [1:0]   dir_cmd_out,
  output reg          run_cmd_out,
  output reg          ramp_normal_out,
  output reg  [2:0]   step_out,
  output reg          seq_active_out,
  output reg          dcb_active_out,
  output reg          fault_latched_out,
  output reg          power_up_start_blocked_indication_out
);
  localparam ST_IDLE  = 2'h0;
  localparam ST_RUN   = 2'h1;
  localparam ST_HOLD  = 2'h2;
  localparam ST_DONE  = 2'h3;

  // Time settings are in 0.1 s units, one tick each, so 3600.0 s fits in 16 bits
  function [15:0] step_time;
    input [2:0] idx;
    step_time = step_time_in[idx*16 +: 16];
  endfunction

  function [15:0] step_freq;
    input [2:0] idx;
    if (idx == 3'h0)
      step_freq = keypad_freq_in;                                      // RULE7
    else
      step_freq = step_freq_in[(idx-3'h1)*16 +: 16];                   // RULE6
  endfunction

  wire tick;
  arsr_tick #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .tick_out (tick)
  );

  reg [4:0]  di_s1_reg, di_s2_reg;
  reg [2:0]  ctl_s1_reg, ctl_s2_reg;
  reg        uv_d_reg;
  reg [1:0]  state_reg;
  reg [2:0]  step_reg;
  reg [15:0] time_reg;
  reg        blocked_reg, uv_stop_reg;
  reg [1:0]  pu_cnt_reg;
  reg [3:0]  tries_reg;
  reg [13:0] dly_reg;
  reg        pend_reg;
  reg [15:0] saved_freq_reg;
  reg [2:0]  flash_reg;
  integer    i;

  wire run_sw   = ctl_s2_reg[0];
  wire uv       = ctl_s2_reg[1];
  wire rst_req  = ctl_s2_reg[2];
  reg  seq_en;
  always @* begin
    seq_en = 1'b0;
    for (i = 0; i < 5; i = i + 1)
      if (di_func_in[i*5 +: 5] == `ARSR_DI_FUNC_SEQ && di_s2_reg[i])
        seq_en = 1'b1;                                                  // RULE10
  end
  wire seq_on   = seq_en && seq_mode_in != `ARSR_MODE_OFF
                  && seq_mode_in <= `ARSR_MODE_MAX;                     // RULE1
  wire resume   = seq_mode_in <= 3'h3;                                  // RULE2
  wire periodic = seq_mode_in == 3'h2 || seq_mode_in == 3'h5;           // RULE4
  wire holdlast = seq_mode_in == 3'h3 || seq_mode_in == 3'h6;           // RULE5
  wire [2:0] nxt = step_reg + 3'h1;
  wire last_step = step_reg == 3'h7 || step_time(nxt) == 16'h0;         // RULE22
  // No run until the synchroniser has shown the real switch level after power-up
  wire run_ok = run_sw && !blocked_reg && !uv_stop_reg && !fault_latched_out && !pend_reg
                && pu_cnt_reg == 2'h3;
  wire dcb_en = dcb_current_in != 8'h0 && dcb_time_in != 8'h0;          // RULE20
  wire [15:0] dcb_thr = ({6'h0, dcb_start_freq_in} < min_freq_in) ?
                        min_freq_in : {6'h0, dcb_start_freq_in};        // RULE21
  localparam [13:0] INT_DLY = `ARSR_INT_DELAY_TICKS;
  wire [13:0] dly_load = (restart_delay_in == 14'h0) ?
                         INT_DLY : restart_delay_in;                    // RULE15

  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      di_s1_reg <= 5'h0;
      di_s2_reg <= 5'h0;
      ctl_s1_reg <= 3'h0;
      ctl_s2_reg <= 3'h0;
    end else begin
      di_s1_reg <= di_pin_in;
      di_s2_reg <= di_s1_reg;
      ctl_s1_reg <= {fault_reset_in, undervolt_in, run_sw_in};
      ctl_s2_reg <= ctl_s1_reg;
    end
  end

  // Start supervision: power-up, power loss, fault restart
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      uv_d_reg <= 1'b0;
      blocked_reg <= 1'b0;
      pu_cnt_reg <= 2'h0;
      uv_stop_reg <= 1'b0;
      fault_latched_out <= 1'b0;
      tries_reg <= 4'h0;
      dly_reg <= 14'h0;
      pend_reg <= 1'b0;
      saved_freq_reg <= 16'h0;
      flash_reg <= 3'h0;
      power_up_start_blocked_indication_out <= 1'b0;
    end else begin
      uv_d_reg <= uv;
      if (pu_cnt_reg != 2'h3)
        pu_cnt_reg <= pu_cnt_reg + 2'h1;
      // Third edge after release: the synchroniser now carries the switch level
      if (pu_cnt_reg == 2'h2) begin
        if (run_sw && ext_run_sel_in && direct_run_off_in)
          blocked_reg <= 1'b1;                                          // RULE19
      end else if (pu_cnt_reg == 2'h3 && !run_sw)
        blocked_reg <= 1'b0;                                            // RULE18
      if (tick)
        flash_reg <= flash_reg + 3'h1;
      power_up_start_blocked_indication_out <= blocked_reg && flash_reg[2]; // RULE19
      if (uv) begin
        uv_stop_reg <= 1'b1;                                            // RULE12
        if (!uv_d_reg)
          saved_freq_reg <= out_freq_in;
      end else if (uv_stop_reg && pwr_loss_restart_in)
        uv_stop_reg <= 1'b0;                                            // RULE13
      else if (uv_stop_reg && !run_sw)
        uv_stop_reg <= 1'b0;
      if (fault_in && !fault_latched_out) begin
        fault_latched_out <= 1'b1;
        saved_freq_reg <= out_freq_in;
        if (tries_reg < restart_count_in && !dcb_active_out && !decel_stop_in) begin
          pend_reg <= 1'b1;                                             // RULE14 RULE16
          dly_reg <= dly_load;
          tries_reg <= tries_reg + 4'h1;
        end
      end else if (pend_reg) begin
        if (tick) begin
          if (dly_reg <= 14'h1) begin
            pend_reg <= 1'b0;                                           // RULE15
            fault_latched_out <= 1'b0;
          end else
            dly_reg <= dly_reg - 14'h1;
        end
      end else if (fault_latched_out && rst_req && (reset_mode_in || !run_sw)) begin
        fault_latched_out <= 1'b0;                                      // RULE17
        tries_reg <= 4'h0;
      end
    end
  end

  // Step sequencing
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_reg <= ST_IDLE;
      step_reg <= 3'h0;
      time_reg <= 16'h0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (seq_on && run_ok) begin
            state_reg <= ST_RUN;
            if (!resume) begin
              step_reg <= 3'h0;                                         // RULE2
              time_reg <= 16'h0;
            end
          end
        end
        ST_RUN: begin
          if (!(seq_on && run_ok))
            state_reg <= ST_IDLE;
          else if (tick) begin
            if (time_reg + 16'h1 >= step_time(step_reg)) begin          // RULE8
              time_reg <= 16'h0;
              if (!last_step)
                step_reg <= nxt;
              else if (periodic)
                step_reg <= 3'h0;                                       // RULE4
              else if (holdlast)
                state_reg <= ST_HOLD;                                   // RULE5
              else
                state_reg <= ST_DONE;                                   // RULE3
            end else
              time_reg <= time_reg + 16'h1;
          end
        end
        ST_HOLD: begin
          if (!(seq_on && run_ok)) begin
            state_reg <= ST_IDLE;
            step_reg <= 3'h0;
          end
        end
        ST_DONE: begin
          if (!run_sw || !seq_on) begin
            state_reg <= ST_IDLE;
            step_reg <= 3'h0;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Drive commands
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      freq_cmd_out <= 16'h0;
      dir_cmd_out <= `ARSR_DIR_STOP;
      run_cmd_out <= 1'b0;
      ramp_normal_out <= 1'b1;
      step_out <= 3'h0;
      seq_active_out <= 1'b0;
      dcb_active_out <= 1'b0;
    end else begin
      step_out <= step_reg;
      seq_active_out <= state_reg == ST_RUN || state_reg == ST_HOLD;
      ramp_normal_out <= 1'b1;                                          // RULE11
      if (uv) begin
        run_cmd_out <= 1'b0;                                            // RULE12
        dir_cmd_out <= `ARSR_DIR_STOP;
      end else if ((state_reg == ST_RUN || state_reg == ST_HOLD) && run_ok) begin
        // Refused run drops here at once, not a cycle later with the state
        freq_cmd_out <= step_freq(step_reg);
        dir_cmd_out <= step_dir_in[step_reg*2 +: 2];                    // RULE9
        run_cmd_out <= step_dir_in[step_reg*2 +: 2] != `ARSR_DIR_STOP;
      end else if (!seq_en && run_ok) begin
        freq_cmd_out <= (uv_d_reg || pwr_loss_restart_in) ? saved_freq_reg : keypad_freq_in;
        dir_cmd_out <= `ARSR_DIR_FWD;
        run_cmd_out <= 1'b1;                                            // RULE13
      end else begin
        run_cmd_out <= 1'b0;
        dir_cmd_out <= `ARSR_DIR_STOP;
      end
      dcb_active_out <= dcb_en && !run_cmd_out && decel_stop_in
                        && out_freq_in <= dcb_thr;                      // RULE20 RULE21
    end
  end
endmodule // arsr_seq

// *** arsr_seq_properties.sv ***
// Concurrent checks on the sequencer top ports.
// Assumes set-up inputs stay static between resets.
module arsr_seq_chk (
  input wire         clk_in,
  input wire         rst_in,
  input wire [2:0]   seq_mode_in,
  input wire [15:0]  keypad_freq_in,
  input wire [111:0] step_freq_in,
  input wire [15:0]  step_dir_in,
  input wire [3:0]   restart_count_in,
  input wire [7:0]   dcb_current_in,
  input wire [7:0]   dcb_time_in,
  input wire         undervolt_in,
  input wire [15:0]  freq_cmd_out,
  input wire [1:0]   dir_cmd_out,
  input wire         run_cmd_out,
  input wire         ramp_normal_out,
  input wire [2:0]   step_out,
  input wire         seq_active_out,
  input wire         dcb_active_out,
  input wire         fault_latched_out,
  input wire         power_up_start_blocked_indication_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  wire sr = run_cmd_out && seq_active_out;
  chk_ramp_normal:
    assert property (ramp_normal_out) else $error("ramp pair not normal");
  chk_mode_off:
    assert property (seq_mode_in == 3'h0 |-> !seq_active_out) else $error("sequencer on in mode 0");
  chk_step0_freq:
    assert property (sr && step_out == 3'h0 |-> freq_cmd_out == keypad_freq_in)
      else $error("step 0 frequency wrong");
  chk_step_freq:
    assert property (sr && step_out != 3'h0 |-> freq_cmd_out == step_freq_in[(step_out-3'h1)*16+:16])
      else $error("step frequency wrong");
  chk_step_dir:
    assert property (sr |-> dir_cmd_out == step_dir_in[step_out*2+:2]) else $error("step dir wrong");
  chk_uv_stop:
    assert property (undervolt_in [*5] |-> !run_cmd_out) else $error("running in under-voltage");
  chk_fault_hold:
    assert property (fault_latched_out && $past(fault_latched_out) && restart_count_in == 4'h0
      |-> !run_cmd_out) else $error("running with fault latched");
  chk_dcb_enable:
    assert property (dcb_active_out |-> dcb_current_in != 8'h00 && dcb_time_in != 8'h00)
      else $error("brake without settings");
  chk_blocked_off:
    assert property (power_up_start_blocked_indication_out |-> !run_cmd_out)
      else $error("running while blocked");
  cov_last_step: cover property (sr && step_out == 3'h3);
  cov_fault: cover property (fault_latched_out);
  cov_brake: cover property (dcb_active_out);
endmodule // arsr_seq_chk
bind arsr_seq arsr_seq_chk arsr_seq_chk_i (.*);

// *** arsr_seq_tb_top.sv ***
// Self-checking bench for the sequencer and start/stop supervisor.
// Assumes a 10-cycle tick so step and restart times stay short.
module arsr_seq_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  reg         clk_in = 1'b0, rst_in = 1'b1, run_req = 1'b0, seq_req = 1'b0;
  reg [2:0]   seq_mode_in = 3'h0;
  reg [15:0]  keypad_freq_in = 16'hE9FC, step_dir_in = 16'h0000;
  reg [15:0]  min_freq_in = 16'h01F4, out_freq_in = 16'h0190;
  reg [111:0] step_freq_in = 112'h0;
  reg [127:0] step_time_in = 128'h0;
  reg [24:0]  di_func_in = 25'h0000012;
  reg [13:0]  restart_delay_in = 14'h0000;
  reg [3:0]   restart_count_in = 4'h0;
  reg [7:0]   dcb_current_in = 8'h10, dcb_time_in = 8'h10;
  reg [9:0]   dcb_start_freq_in = 10'h00A;
  reg         pwr_loss_restart_in = 1'b0, reset_mode_in = 1'b0, direct_run_off_in = 1'b0;
  reg         ext_run_sel_in = 1'b1, undervolt_in = 1'b0, fault_in = 1'b0;
  reg         fault_reset_in = 1'b0, decel_stop_in = 1'b0;
  wire        run_sw_in, run_cmd_out, ramp_normal_out, seq_active_out, dcb_active_out;
  wire        fault_latched_out, power_up_start_blocked_indication_out;
  wire [4:0]  di_pin_in;
  wire [15:0] freq_cmd_out;
  wire [1:0]  dir_cmd_out;
  wire [2:0]  step_out;
  int         bad_count = 0, tests_run = 0, m, k;
  arsr_seq #(.TICK_CYCLES(10)) arsr_seq_i (.*);
  arsr_op_model arsr_op_model_i (.clk_in(clk_in), .run_req_in(run_req), .seq_req_in(seq_req),
    .run_sw_out(run_sw_in), .di_pin_out(di_pin_in));
  always #10 clk_in = ~clk_in;
  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic logic hit(int sel);
    case (sel)
      0: hit = run_cmd_out === 1'b1;
      1: hit = run_cmd_out === 1'b0;
      2: hit = dcb_active_out === 1'b1;
      3: hit = power_up_start_blocked_indication_out === 1'b1;
      default: hit = step_out === 3'(sel - 4);
    endcase
  endfunction
  task automatic wait_for(int sel, int lim);
    int n;
    n = 0;
    while (!hit(sel) && n < lim) begin
      @(posedge clk_in);
      n++;
    end
  endtask
  task automatic cyc(int c);
    repeat (c) @(posedge clk_in);
  endtask
  // Steps 0-3 get 4-6 ticks and a running direction; step 4 ends the cycle
  task automatic setup(int md);
    seq_mode_in <= md[2:0];
    for (k = 0; k < 8; k++) begin
      step_time_in[k*16+:16] <= (k < 4) ? 16'($urandom_range(6, 4)) : 16'h0000;
      step_dir_in[k*2+:2] <= (k < 4) ? 2'($urandom_range(2, 1)) : 2'h0;
      step_freq_in[(k%7)*16+:16] <= 16'($urandom_range(59900));
    end
    rst_in <= 1'b1;
    cyc(12);
    rst_in <= 1'b0;
    cyc(3);
  endtask
  task automatic final_report();
    $display("Checks %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    cyc(60000);
    bad_count++;
    final_report();
  end
  initial begin
    m = $urandom(90);
    for (m = 1; m < 7; m++) begin
      setup(m);
      run_req <= 1'b1;
      seq_req <= 1'b1;
      wait_for(6, 400);
      run_req <= 1'b0;
      wait_for(1, 20);
      run_req <= 1'b1;
      wait_for(0, 20);
      check("resume step", step_out, m < 4 ? 2 : 0);
      check("resume dir", dir_cmd_out, step_dir_in[(m < 4 ? 4 : 0)+:2]);
      check("seq active", seq_active_out, 1);
      wait_for(7, 800);
      if (m % 3 == 2) wait_for(4, 200);
      else cyc(100);
      check("run after cycle", run_cmd_out, m % 3 != 1);
      if (m % 3 == 2) check("wrap step", step_out, 0);
      if (m % 3 == 0) check("hold freq", freq_cmd_out, step_freq_in[32+:16]);
    end
    for (m = 0; m < 2; m++) begin
      pwr_loss_restart_in <= m[0];
      setup(2);
      wait_for(0, 40);
      undervolt_in <= 1'b1;
      cyc(10);
      check("uv stop", run_cmd_out, 0);
      undervolt_in <= 1'b0;
      wait_for(0, 100);
      check("uv restart", run_cmd_out, m);
    end
    // Restart-allowed case first, so a latched fault is left for the reset checks
    for (m = 1; m >= 0; m--) begin
      restart_count_in <= m[3:0];
      setup(2);
      wait_for(0, 40);
      fault_in <= 1'b1;
      cyc(3);
      fault_in <= 1'b0;
      cyc(30);
      check("restart delay", run_cmd_out, 0);
      wait_for(0, 200);
      check("auto restart", run_cmd_out, m);
    end
    fault_reset_in <= 1'b1;
    cyc(6);
    fault_reset_in <= 1'b0;
    run_req <= 1'b0;
    cyc(6);
    check("reset with run on", fault_latched_out, 1);
    fault_reset_in <= 1'b1;
    cyc(6);
    fault_reset_in <= 1'b0;
    cyc(4);
    check("reset with run off", fault_latched_out, 0);
    for (m = 0; m < 2; m++) begin
      direct_run_off_in <= m[0];
      seq_req <= 1'b0;
      run_req <= 1'b1;
      setup(0);
      wait_for(3, 700);
      check("blocked flash", power_up_start_blocked_indication_out, m);
      check("power-up run", run_cmd_out, m == 0);
      run_req <= 1'b0;
      cyc(8);
      run_req <= 1'b1;
      wait_for(0, 20);
      check("run after toggle", run_cmd_out, 1);
      dcb_current_in <= m ? 8'h10 : 8'h00;
      run_req <= 1'b0;
      decel_stop_in <= 1'b1;
      wait_for(2, 40);
      check("dc brake", dcb_active_out, m);
      decel_stop_in <= 1'b0;
    end
    final_report();
  end
endmodule // arsr_seq_tb_top

// *** arsr_tick.v ***
// Prescaler producing a one-cycle tick every 100 ms.
// Assumes one clock and an asynchronous active-high reset.
`include "arsr_defs.vh"
module arsr_tick #(
  parameter TICK_CYCLES = `ARSR_TICK_CYCLES
) (
  // Clock and reset
  input  wire clk_in,
  input  wire rst_in,
  // Tick
  output reg  tick_out
);
  reg [31:0] cnt_reg;

  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_reg  <= 32'h0;
      tick_out <= 1'b0;
    end else if (cnt_reg >= TICK_CYCLES - 1) begin
      cnt_reg  <= 32'h0;
      tick_out <= 1'b1;
    end else begin
      cnt_reg  <= cnt_reg + 32'h1;
      tick_out <= 1'b0;
    end
  end
endmodule // arsr_tick
